// >>> verilog/sscirq_pkg.sv
package sscirq_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFFS_FLAGS = 12'h000;
    localparam logic [11:0] OFFS_ENABLES = 12'h004;
    localparam logic [31:0] RESET_FLAGS = 32'h0000_0000;
    localparam logic [31:0] RESET_ENABLES = 32'h0000_0000;
    localparam int NUM_EVT = 4;
    localparam int BIT_CARD_STATUS = 0;
    localparam int BIT_DETECT_ONE = 1;
    localparam int BIT_DETECT_TWO = 2;
    localparam int BIT_POWER_CYCLE = 3;
    localparam logic [1:0] DETECT_EN_ON = 2'b11;
    localparam logic [27:0] RSVD_ZERO = 28'h000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic power_cycle_state;
        logic detect_two_state;
        logic detect_one_state;
        logic card_status_state;
    } sscirq_status_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sscirq_req_t;

    typedef enum logic [1:0] {
        SSC_RUN = 2'b00,
        SSC_CRST = 2'b01,
        SSC_REARM = 2'b10
    } sscirq_state_t;
endpackage : sscirq_pkg

// >>> verilog/sscirq_edge.sv
`timescale 1ns/100ps
// Change detector for one watched status line
module sscirq_edge (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic level,
    input wire logic rise_only,
    input wire logic rearm,
    output logic hit
);
    logic prev_q;
    logic prev_d;
    wire logic rose = level & ~prev_q;
    wire logic fell = ~level & prev_q;

    assign prev_d = level;
    // Rearm re-reports a still-asserted level after card reset
    assign hit = rose | (fell & ~rise_only) | (rearm & level);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end
endmodule : sscirq_edge

// >>> verilog/sscirq_regs.sv
`timescale 1ns/100ps
// Register read mux
module sscirq_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire sscirq_pkg::sscirq_req_t req,
    input wire logic [3:0] flags,
    input wire logic [3:0] enables,
    output logic [31:0] rdata
);
    logic [31:0] rdata_q;
    wire logic sel_flags = req.addr == sscirq_pkg::OFFS_FLAGS;
    wire logic sel_en = req.addr == sscirq_pkg::OFFS_ENABLES;
    wire logic [31:0] rdata_d = !req.rd ? rdata_q :
        sel_flags ? {sscirq_pkg::RSVD_ZERO, flags} :
        sel_en ? {sscirq_pkg::RSVD_ZERO, enables} : 32'h0000_0000;

    assign rdata = rdata_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
endmodule : sscirq_regs

// >>> verilog/sscirq_top.sv
`timescale 1ns/100ps
// Operation
// - Flags record change only, not new value
// - Writing one clears flag, zero keeps
// - Force write of one sets flag
// - Bus reset clears every flag
// - Leaving card reset re-sets flags of lines still high, except power cycle
// - Bits 31 to 4 read zero
// - Power-cycle change sets flag bit 3
// - Detect-two change sets flag bit 2
// - Detect-one change sets flag bit 1
// - CardBus card: rising card status only
// - 16-bit card: both card status edges
// - Enables never stop flags being set
// - Enable bit 3 gates power-cycle interrupt
// - Detect enable field 11 on, 00 off
// - Enable bit 0 gates card-status interrupt
// - Registers at offsets from socket base
module sscirq_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire sscirq_pkg::sscirq_req_t req,
    output logic [31:0] rdata,
    input wire sscirq_pkg::sscirq_status_t status,
    input wire logic cardbus_card,
    input wire logic card_reset,
    input wire logic [3:0] force_set,
    output logic status_change_interrupt
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [3:0] enables_q;
    logic [3:0] enables_d;
    logic crst_q;
    logic [3:0] hit;
    logic [3:0] lvl;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Socket base is decoded upstream; only the offset arrives here
    wire logic wr_flags = req.wr && req.addr == sscirq_pkg::OFFS_FLAGS;
    wire logic wr_en = req.wr && req.addr == sscirq_pkg::OFFS_ENABLES;
    wire logic rearm = crst_q & ~card_reset;
    wire logic [3:0] clr = wr_flags ? req.wdata[3:0] : 4'h0;

    assign lvl = status;

    genvar g;
    generate
        for (g = 0; g < sscirq_pkg::NUM_EVT; g++) begin : g_evt
            sscirq_edge u_edge (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .level(lvl[g]),
                .rise_only((g == sscirq_pkg::BIT_CARD_STATUS) && cardbus_card),
                .rearm(rearm && (g != sscirq_pkg::BIT_POWER_CYCLE)),
                .hit(hit[g])
            );
        end
    endgenerate

    // Set wins over clear; enables play no part here
    assign flags_d = (flags_q & ~clr) | hit | force_set;
    assign enables_d = wr_en ? req.wdata[3:0] : enables_q;

    // Detect flags share the two-bit field; only 11 enables them
    wire logic det_on = enables_q[2:1] == sscirq_pkg::DETECT_EN_ON;
    wire logic irq_d = (flags_q[sscirq_pkg::BIT_POWER_CYCLE] & enables_q[3])
        | ((flags_q[sscirq_pkg::BIT_DETECT_ONE] | flags_q[sscirq_pkg::BIT_DETECT_TWO]) & det_on)
        | (flags_q[sscirq_pkg::BIT_CARD_STATUS] & enables_q[0]);

    assign status_change_interrupt = irq_d;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flags_q <= sscirq_pkg::RESET_FLAGS[3:0];
            enables_q <= sscirq_pkg::RESET_ENABLES[3:0];
            crst_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            enables_q <= enables_d;
            crst_q <= card_reset;
        end
    end

    sscirq_regs u_regs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .req(req),
        .flags(flags_q),
        .enables(enables_q),
        .rdata(rdata)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    reset_clear_a: assert property ($past(sys_rst) |-> flags_q == 4'h0 && enables_q == 4'h0)
        else $error("flags or enables not zero after reset");
    clear_one_a: assert property (wr_flags && req.wdata[0] && !hit[0] && !force_set[0]
        |=> !flags_q[0])
        else $error("write one did not clear flag");
    force_set_a: assert property (force_set[2] |=> flags_q[2])
        else $error("force did not set flag");
    power_change_a: assert property ($changed(status.power_cycle_state) |=> flags_q[3])
        else $error("power change missed");
    detect_change_a: assert property ($changed(status.detect_one_state) |=> flags_q[1])
        else $error("detect one change missed");
    cb_fall_a: assert property (cardbus_card && $fell(status.card_status_state)
        && !rearm && !force_set[0] && !flags_q[0] |=> !flags_q[0])
        else $error("cardbus fall set flag");
    pc16_fall_a: assert property (!cardbus_card && $fell(status.card_status_state)
        |=> flags_q[0])
        else $error("16-bit fall missed");
    rsvd_zero_a: assert property ($past(req.rd) |-> rdata[31:4] == 28'h000_0000)
        else $error("reserved bits nonzero");
    irq_gate_a: assert property (enables_q == 4'h0 |-> !status_change_interrupt)
        else $error("interrupt with all enables off");
    rearm_a: assert property (rearm && status.detect_two_state |=> flags_q[2])
        else $error("rearm missed");

    irq_seen_c: cover property (status_change_interrupt);
    clear_seen_c: cover property (flags_q[0] ##1 !flags_q[0]);
    rearm_seen_c: cover property (rearm);
endmodule : sscirq_top

// >>> tb/sscirq_sock_model.sv
`timescale 1ns/100ps
// Socket side: watched status levels and card type, held until changed
module sscirq_sock_model (
    input wire logic core_clk,
    output sscirq_pkg::sscirq_status_t status,
    output logic cardbus_card
);
    initial begin
        status = '0;
        cardbus_card = 1'b0;
    end
    // Called just after an edge so levels never move on the sampling edge
    task automatic drive(input logic [3:0] s, input logic cb);
        status = s;
        cardbus_card = cb;
    endtask : drive
endmodule : sscirq_sock_model

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
    logic core_clk;
    logic sys_rst;
    sscirq_pkg::sscirq_req_t req;
    logic [31:0] rdata;
    sscirq_pkg::sscirq_status_t status;
    logic cardbus_card, card_reset, status_change_interrupt;
    logic [3:0] force_set;
    int failures, cmp_count, cycles;
    // Rows: card type, status levels, flags expected
    logic [8:0] rows [8] = '{9'h111, 9'h100, 9'h011, 9'h001, 9'h022, 9'h064, 9'h0E8, 9'h00E};
    logic [3:0] en [4] = '{4'h1, 4'h6, 4'h6, 4'h8};
    sscirq_top u_sscirq_top (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .status(status), .cardbus_card(cardbus_card), .card_reset(card_reset),
        .force_set(force_set), .status_change_interrupt(status_change_interrupt));
    sscirq_sock_model u_sscirq_sock_model (.core_clk(core_clk), .status(status),
        .cardbus_card(cardbus_card));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        cyc(1);
        req.wr = 1'b0;
        // Idle edge so a following strobe is never re-raised in the same step
        cyc(1);
    endtask : wr
    // Read data lands at the edge that takes the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        req.addr = a;
        req.rd = 1'b1;
        cyc(1);
        req.rd = 1'b0;
        check(rdata, exp);
        cyc(1);
    endtask : rd
    task automatic results();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        sys_rst = 1'b1;
        req = '0;
        card_reset = 1'b0;
        force_set = 4'h0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        cyc(16);
        sys_rst = 1'b0;
        rd(sscirq_pkg::OFFS_FLAGS, sscirq_pkg::RESET_FLAGS);
        rd(sscirq_pkg::OFFS_ENABLES, sscirq_pkg::RESET_ENABLES);
        foreach (rows[i]) begin
            u_sscirq_sock_model.drive(rows[i][7:4], rows[i][8]);
            cyc(2);
            rd(sscirq_pkg::OFFS_FLAGS, 32'(rows[i][3:0]));
            check(32'(status_change_interrupt), 32'h0000_0000);
            wr(sscirq_pkg::OFFS_FLAGS, 32'h0000_000F);
        end
        wr(sscirq_pkg::OFFS_ENABLES, 32'hFFFF_FFFF);
        rd(sscirq_pkg::OFFS_ENABLES, 32'h0000_000F);
        rd(12'h008, 32'h0000_0000);
        wr(sscirq_pkg::OFFS_ENABLES, 32'h0000_0000);
        foreach (en[i]) begin
            force_set = 4'h1 << i;
            cyc(1);
            force_set = 4'h0;
            wr(sscirq_pkg::OFFS_FLAGS, 32'h0000_0000);
            rd(sscirq_pkg::OFFS_FLAGS, 32'(4'h1 << i));
            check(32'(status_change_interrupt), 32'h0000_0000);
            wr(sscirq_pkg::OFFS_ENABLES, 32'(en[i]));
            check(32'(status_change_interrupt), 32'h0000_0001);
            wr(sscirq_pkg::OFFS_FLAGS, 32'(4'h1 << i));
            check(32'(status_change_interrupt), 32'h0000_0000);
            wr(sscirq_pkg::OFFS_ENABLES, 32'h0000_0000);
        end
        // Levels stay high across card reset, so flags must come back
        u_sscirq_sock_model.drive(4'h3, 1'b0);
        cyc(2);
        wr(sscirq_pkg::OFFS_FLAGS, 32'h0000_000F);
        card_reset = 1'b1;
        cyc(1);
        card_reset = 1'b0;
        cyc(3);
        rd(sscirq_pkg::OFFS_FLAGS, 32'h0000_0003);
        // Lines low first: a high line at release would report a change
        u_sscirq_sock_model.drive(4'h0, 1'b0);
        cyc(2);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        rd(sscirq_pkg::OFFS_FLAGS, 32'h0000_0000);
        results();
    end
endmodule : tb
